/* File: dbl_dev_model.sv */
// Behavioural model of the dual converter byte-load device
module dbl_dev_model
(
	// Bus pins
	input  wire logic        chip_sel_n_in,
	input  wire logic        write_n_in,
	input  wire logic        latch_sel_high_in,
	input  wire logic        latch_sel_low_in,
	input  wire logic [7:0]  data_in,
	input  wire logic        output_update_strobe_n_in,
	// Converter codes
	output logic      [11:0] dac_a_out,
	output logic      [11:0] dac_b_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] in_a = 12'h000;
	logic [11:0] in_b = 12'h000;
	initial
	begin
		dac_a_out = 12'h000;
		dac_b_out = 12'h000;
	end
	always @*
	begin
		if (!chip_sel_n_in && !write_n_in)
		begin
			case ({latch_sel_high_in, latch_sel_low_in})
				2'h0: in_a[7:0] = data_in;
				2'h1: in_a[11:8] = data_in[3:0];
				2'h2: in_b[7:0] = data_in;
				default: in_b[11:8] = data_in[3:0];
			endcase
		end
	end
	always @*
	begin
		if (!output_update_strobe_n_in)
		begin
			dac_a_out = in_a;
			dac_b_out = in_b;
		end
	end
endmodule

/* File: dbl_host.sv */
// Host controller that loads a dual 12-bit byte-wide converter and strobes its update
module dbl_host
(
	// Clock and reset
	input  wire logic                            mclk_in,
	input  wire logic                            nrst_in,
	// Request
	input  wire logic                            req_valid_in,
	input  wire logic                            req_write_a_in,
	input  wire logic                            req_write_b_in,
	input  wire logic                            req_update_in,
	input  wire logic                            req_bipolar_in,
	input  wire logic [dbl_pkg::CODE_W-1:0]      req_code_a_in,
	input  wire logic [dbl_pkg::CODE_W-1:0]      req_code_b_in,
	output logic                                 req_ready_out,
	output logic                                 req_done_out,
	// Converter pins
	output logic                                 chip_sel_n_out,
	output logic                                 write_n_out,
	output logic                                 latch_sel_high_out,
	output logic                                 latch_sel_low_out,
	output logic [dbl_pkg::DATA_W-1:0]           data_out,
	output logic                                 output_update_strobe_n_out
);
	import dbl_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		dbl_state_e          st;
		logic [3:0]          mask;
		logic [1:0]          part;
		logic [CODE_W-1:0]   code_a;
		logic [CODE_W-1:0]   code_b;
		logic                upd;
		logic                ready;
		logic                done;
		logic                cs_n;
		logic                wr_n;
		logic                sel_high;
		logic                sel_low;
		logic [DATA_W-1:0]   data;
		logic                upd_n;
	} dbl_host_s;

	dbl_host_s r;
	dbl_host_s next_r;

	logic              tmr_load;
	logic [TMR_W-1:0]  tmr_value;
	logic              tmr_zero;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Lowest pending part: {found, index}
	function automatic logic [2:0] first_part(input logic [3:0] mask);
		logic [2:0] res;
		res = 3'h0;
		if (mask[0])
			res = {1'b1, PART_A_LOW};
		else if (mask[1])
			res = {1'b1, PART_A_HIGH};
		else if (mask[2])
			res = {1'b1, PART_B_LOW};
		else if (mask[3])
			res = {1'b1, PART_B_HIGH};
		return res;
	endfunction

	// Byte for a part, right-justified
	function automatic logic [DATA_W-1:0] part_byte(input logic [1:0] part,
	                                                input logic [CODE_W-1:0] ca,
	                                                input logic [CODE_W-1:0] cb);
		logic [CODE_W-1:0] c;
		c = part[1] ? cb : ca;
		if (part[0])
			return {HIGH_PAD, c[CODE_W-1:DATA_W]};
		return c[DATA_W-1:0];
	endfunction

	// ----------------------------------------
	// Phase timer
	// ----------------------------------------
	dbl_timer #(.W(TMR_W)) u_timer
	(
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.load_in  (tmr_load),
		.value_in (tmr_value),
		.zero_out (tmr_zero)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		logic [2:0] nxt;
		logic [3:0] rest;
		nxt       = 3'h0;
		rest      = 4'h0;
		next_r    = r;
		tmr_load  = 1'b0;
		tmr_value = '0;
		next_r.done = 1'b0;
		case (r.st)
			DBL_IDLE:
			begin
				if (req_valid_in)
				begin
					next_r.ready  = 1'b0;
					next_r.mask   = {req_write_b_in, req_write_b_in, req_write_a_in, req_write_a_in};
					next_r.code_a = req_bipolar_in ? (req_code_a_in ^ BIPOLAR_FLIP) : req_code_a_in;
					next_r.code_b = req_bipolar_in ? (req_code_b_in ^ BIPOLAR_FLIP) : req_code_b_in;
					next_r.upd    = req_update_in;
					next_r.st     = DBL_GAP;
					tmr_load      = 1'b1;
					tmr_value     = TMR_W'(0);
				end
			end
			DBL_SETUP:
			begin
				if (tmr_zero)
				begin
					next_r.wr_n = 1'b0;
					next_r.st   = DBL_STROBE;
					tmr_load    = 1'b1;
					tmr_value   = TMR_W'(WR_CYC - 1);
				end
			end
			DBL_STROBE:
			begin
				if (tmr_zero)
				begin
					next_r.wr_n = 1'b1;
					next_r.st   = DBL_HOLD;
					tmr_load    = 1'b1;
					tmr_value   = TMR_W'(HOLD_CYC - 1);
				end
			end
			DBL_HOLD:
			begin
				if (tmr_zero)
				begin
					rest           = r.mask;
					rest[r.part]   = 1'b0;
					next_r.mask    = rest;
					next_r.cs_n    = 1'b1;
					next_r.st      = DBL_GAP;
					tmr_load       = 1'b1;
					tmr_value      = TMR_W'(GAP_CYC - 1);
				end
			end
			DBL_GAP:
			begin
				if (tmr_zero)
				begin
					nxt = first_part(r.mask);
					if (nxt[2])
					begin
						// Low part before high part, A before B
						next_r.part     = nxt[1:0];
						next_r.sel_high = nxt[1];
						next_r.sel_low  = nxt[0];
						next_r.data     = part_byte(nxt[1:0], r.code_a, r.code_b);
						next_r.cs_n     = 1'b0;
						next_r.st       = DBL_SETUP;
						tmr_load        = 1'b1;
						tmr_value       = TMR_W'(SETUP_CYC - 1);
					end
					else if (r.upd)
					begin
						// Strobe only once select and write are high
						next_r.upd_n = 1'b0;
						next_r.st    = DBL_UPDATE;
						tmr_load     = 1'b1;
						tmr_value    = TMR_W'(UPDATE_CYC - 1);
					end
					else
					begin
						next_r.ready = 1'b1;
						next_r.done  = 1'b1;
						next_r.st    = DBL_IDLE;
					end
				end
			end
			DBL_UPDATE:
			begin
				if (tmr_zero)
				begin
					next_r.upd_n = 1'b1;
					next_r.upd   = 1'b0;
					next_r.st    = DBL_GAP;
					tmr_load     = 1'b1;
					tmr_value    = TMR_W'(GAP_CYC - 1);
				end
			end
			default:
			begin
				next_r.st = DBL_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			r          <= '0;
			r.st       <= DBL_IDLE;
			r.code_a   <= CODE_RST;
			r.code_b   <= CODE_RST;
			r.data     <= DATA_RST;
			r.ready    <= 1'b1;
			r.cs_n     <= 1'b1;
			r.wr_n     <= 1'b1;
			r.upd_n    <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign req_ready_out              = r.ready;
	assign req_done_out               = r.done;
	assign chip_sel_n_out             = r.cs_n;
	assign write_n_out                = r.wr_n;
	assign latch_sel_high_out         = r.sel_high;
	assign latch_sel_low_out          = r.sel_low;
	assign data_out                   = r.data;
	assign output_update_strobe_n_out = r.upd_n;

endmodule

/* File: dbl_host_sva.sv */
// Assertions on the host controller pins
module dbl_host_sva
(
	input wire logic                       mclk_in,
	input wire logic                       nrst_in,
	input wire logic                       req_valid_in,
	input wire logic                       req_write_a_in,
	input wire logic                       req_write_b_in,
	input wire logic                       req_update_in,
	input wire logic [dbl_pkg::CODE_W-1:0] req_code_a_in,
	input wire logic                       req_ready_out,
	input wire logic                       chip_sel_n_out,
	input wire logic                       write_n_out,
	input wire logic                       latch_sel_high_out,
	input wire logic                       latch_sel_low_out,
	input wire logic [dbl_pkg::DATA_W-1:0] data_out,
	input wire logic                       output_update_strobe_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import dbl_pkg::*;
	logic       take;
	logic [7:0] cap;
	assign take = req_valid_in && req_ready_out;
	always_ff @(posedge mclk_in)
		if (take)
			cap <= req_code_a_in[7:0];
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	a_upd_apart: assert property (!output_update_strobe_n_out |-> chip_sel_n_out && write_n_out)
		else $error("update overlaps write");
	a_wr_in_cs: assert property (!write_n_out |-> !chip_sel_n_out)
		else $error("write outside select");
	a_upd_width: assert property ($fell(output_update_strobe_n_out) |->
		!output_update_strobe_n_out[*2] ##1 output_update_strobe_n_out) else $error("update width");
	a_wr_width: assert property ($fell(write_n_out) |-> !write_n_out[*2] ##1 write_n_out)
		else $error("write width");
	a_sel_stable: assert property (!chip_sel_n_out && !$past(chip_sel_n_out) |->
		$stable({latch_sel_high_out, latch_sel_low_out, data_out})) else $error("bus moved");
	a_high_pad: assert property (!chip_sel_n_out && latch_sel_low_out |-> data_out[7:4] == 4'h0)
		else $error("high part pad");
	a_upd_only: assert property (take && req_update_in && !req_write_a_in && !req_write_b_in |->
		##2 !output_update_strobe_n_out) else $error("update late");
	a_low_first: assert property (take && req_write_a_in |-> ##2 (!chip_sel_n_out &&
		!latch_sel_high_out && !latch_sel_low_out && data_out == cap)) else $error("low byte");
	a_b_select: assert property (take && !req_write_a_in && req_write_b_in |->
		##2 (!chip_sel_n_out && latch_sel_high_out && !latch_sel_low_out)) else $error("b select");
	cover property (take && req_write_a_in && req_write_b_in && req_update_in);
	cover property (take && req_update_in && !req_write_a_in && !req_write_b_in);
	cover property ($rose(output_update_strobe_n_out));
endmodule
bind dbl_host dbl_host_sva dbl_host_sva_inst (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
	.req_write_a_in(req_write_a_in), .req_write_b_in(req_write_b_in), .req_update_in(req_update_in),
	.req_code_a_in(req_code_a_in), .req_ready_out(req_ready_out), .chip_sel_n_out(chip_sel_n_out),
	.write_n_out(write_n_out), .latch_sel_high_out(latch_sel_high_out), .latch_sel_low_out(latch_sel_low_out),
	.data_out(data_out), .output_update_strobe_n_out(output_update_strobe_n_out));

/* File: dbl_host_tb.sv */
// Testbench for the host controller against the device model
module dbl_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dbl_pkg::*;
	logic mclk_in = 1'b0, nrst_in = 1'b0;
	logic req_valid_in, req_write_a_in, req_write_b_in, req_update_in, req_bipolar_in, bp;
	logic [CODE_W-1:0] req_code_a_in, req_code_b_in;
	logic req_ready_out, req_done_out, chip_sel_n_out, write_n_out, latch_sel_high_out, latch_sel_low_out, upd_n;
	logic [DATA_W-1:0] data_out;
	logic [11:0] dac_a, dac_b, ia, ib, da, db, ca, cb;
	logic [15:0] lfsr = 16'hbca2;
	int fails = 0, n_tests = 0, n, k;
	`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t %h %h", $time, g, e); end end
	always #25 mclk_in = ~mclk_in;
	dbl_host dbl_host_inst (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
		.req_write_a_in(req_write_a_in), .req_write_b_in(req_write_b_in), .req_update_in(req_update_in),
		.req_bipolar_in(req_bipolar_in), .req_code_a_in(req_code_a_in), .req_code_b_in(req_code_b_in),
		.req_ready_out(req_ready_out), .req_done_out(req_done_out), .chip_sel_n_out(chip_sel_n_out),
		.write_n_out(write_n_out), .latch_sel_high_out(latch_sel_high_out), .latch_sel_low_out(latch_sel_low_out),
		.data_out(data_out), .output_update_strobe_n_out(upd_n));
	dbl_dev_model dbl_dev_model_inst (.chip_sel_n_in(chip_sel_n_out), .write_n_in(write_n_out),
		.latch_sel_high_in(latch_sel_high_out), .latch_sel_low_in(latch_sel_low_out), .data_in(data_out),
		.output_update_strobe_n_in(upd_n), .dac_a_out(dac_a), .dac_b_out(dac_b));
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic end_of_test();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One request, then compare with the reference
	task automatic run(input logic [2:0] f);
		lfsr = step(lfsr);
		ca = lfsr[11:0];
		bp = lfsr[15];
		lfsr = step(lfsr);
		cb = lfsr[11:0];
		@(posedge mclk_in);
		{req_update_in, req_write_b_in, req_write_a_in} <= f;
		{req_bipolar_in, req_code_a_in, req_code_b_in} <= {bp, ca, cb};
		req_valid_in <= 1'b1;
		@(posedge mclk_in);
		req_valid_in <= 1'b0;
		n = 0;
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (req_done_out !== 1'b1 && n < 40);
		k = 1 + 2 * (SETUP_CYC + WR_CYC + HOLD_CYC + GAP_CYC) * (f[0] + f[1]) + (UPDATE_CYC + GAP_CYC) * f[2];
		if (f[0])
			ia = ca ^ {bp, 11'h000};
		if (f[1])
			ib = cb ^ {bp, 11'h000};
		if (f[2])
			{da, db} = {ia, ib};
		`CHK(n - 1, k)
		`CHK({dbl_dev_model_inst.in_a, dbl_dev_model_inst.in_b}, {ia, ib})
		`CHK({dac_a, dac_b}, {da, db})
	endtask
	initial
	begin
		{req_valid_in, req_write_a_in, req_write_b_in, req_update_in, req_bipolar_in} = 5'h00;
		{req_code_a_in, req_code_b_in, ia, ib, da, db} = '0;
		repeat (19) @(posedge mclk_in);
		`CHK({req_ready_out, req_done_out, chip_sel_n_out, write_n_out, upd_n, latch_sel_high_out,
			latch_sel_low_out, data_out}, {7'h5c, 8'h00})
		@(posedge mclk_in);
		nrst_in <= 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			lfsr = step(lfsr);
			run(i < 8 ? i[2:0] : lfsr[2:0]);
		end
		end_of_test();
	end
	initial
	begin
		#200000;
		fails++;
		end_of_test();
	end
endmodule

/* File: dbl_pkg.sv */
// Package of constants and types for the dual converter byte-load host controller
package dbl_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ                = 20;
	localparam int SETUP_NS               = 50;
	localparam int WR_PULSE_NS            = 100;
	localparam int HOLD_NS                = 50;
	localparam int GAP_NS                 = 50;
	localparam int MIN_UPDATE_PULSE_WIDTH = 100;

	localparam int SETUP_CYC  = ((SETUP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int WR_CYC     = ((WR_PULSE_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC   = ((HOLD_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC    = ((GAP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int UPDATE_CYC = ((MIN_UPDATE_PULSE_WIDTH * CLK_MHZ + 999) / 1000 < 1) ? 1
	                            : (MIN_UPDATE_PULSE_WIDTH * CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// Widths, codes and reset values
	// ----------------------------------------
	localparam int TMR_W  = 8;
	localparam int CODE_W = 12;
	localparam int DATA_W = 8;

	localparam logic [CODE_W-1:0] BIPOLAR_FLIP = 12'h800;
	localparam logic [CODE_W-1:0] CODE_RST     = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;
	localparam logic [3:0]        HIGH_PAD     = 4'h0;

	// Part index: bit 1 = channel B, bit 0 = high part
	localparam logic [1:0] PART_A_LOW  = 2'h0;
	localparam logic [1:0] PART_A_HIGH = 2'h1;
	localparam logic [1:0] PART_B_LOW  = 2'h2;
	localparam logic [1:0] PART_B_HIGH = 2'h3;

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		DBL_IDLE   = 3'h4,
		DBL_SETUP  = 3'h1,
		DBL_STROBE = 3'h3,
		DBL_HOLD   = 3'h2,
		DBL_GAP    = 3'h0,
		DBL_UPDATE = 3'h6
	} dbl_state_e;

endpackage

/* File: dbl_timer.sv */
// Loadable down counter that times each phase of a bus cycle
module dbl_timer
#(
	parameter int W = 8
)
(
	// Clock and reset
	input  wire logic         mclk_in,
	input  wire logic         nrst_in,
	// Load
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	// Status
	output logic              zero_out
);

	typedef struct packed
	{
		logic [W-1:0] count;
	} dbl_tmr_s;

	dbl_tmr_s r;
	dbl_tmr_s next_r;

	always_comb
	begin
		next_r = r;
		if (load_in)
			next_r.count = value_in;
		else if (r.count != '0)
			next_r.count = r.count - 1'b1;
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			r <= '0;
		else
			r <= next_r;
	end

	assign zero_out = (r.count == '0);

endmodule
